//--- arp_master.sv
// master end of the read channel port: issues bursts, takes beats
`timescale 1ns/1ps
module arp_master
  import arp_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // link to slave
  arp_rd_if.master rd,
  // command from user logic
  input wire logic cmdValid,
  output logic cmdReady,
  input wire logic [ARP_ID_W-1:0] cmdId,
  input wire logic [ARP_ADDR_W-1:0] cmdAddr,
  input wire logic [ARP_LEN_W-1:0] cmdLen,
  input wire logic [ARP_SIZE_W-1:0] cmdSize,
  input wire logic [ARP_BURST_W-1:0] cmdBurst,
  input wire logic [ARP_LOCK_W-1:0] cmdLock,
  input wire logic [ARP_CACHE_W-1:0] cmdCache,
  input wire logic [ARP_PROT_W-1:0] cmdProt,
  // returned beats to user logic
  input wire logic datStall,
  output logic datValid,
  output logic [ARP_ID_W-1:0] datId,
  output logic [ARP_DATA_W-1:0] datData,
  output arp_resp_t datResp,
  output logic datLast
);

  typedef enum logic [1:0] {IDLE, ADDR, DATA} arp_mstate_t;

  arp_mstate_t state_reg;
  arp_mstate_t state_next;
  logic cmdReady_reg;
  logic arvalid_reg;
  logic rready_reg;
  logic [ARP_ID_W-1:0] arid_reg;
  logic [ARP_ADDR_W-1:0] araddr_reg;
  logic [ARP_LEN_W-1:0] arlen_reg;
  logic [ARP_SIZE_W-1:0] arsize_reg;
  logic [ARP_BURST_W-1:0] arburst_reg;
  logic [ARP_LOCK_W-1:0] arlock_reg;
  logic [ARP_CACHE_W-1:0] arcache_reg;
  logic [ARP_PROT_W-1:0] arprot_reg;
  logic datValid_reg;
  logic [ARP_ID_W-1:0] datId_reg;
  logic [ARP_DATA_W-1:0] datData_reg;
  arp_resp_t datResp_reg;
  logic datLast_reg;
  logic cmdTake;
  logic arDone;
  logic rDone;

  assign cmdTake = cmdValid && cmdReady_reg;
  assign arDone = arvalid_reg && rd.arready;
  assign rDone = rd.rvalid && rready_reg;

  ////////////////////////////////////////////////////////////////////////
  // state sequencing
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      IDLE: begin
        if (cmdTake) begin
          state_next = ADDR;
        end
      end
      ADDR: begin
        if (arDone) begin
          state_next = DATA;
        end
      end
      DATA: begin
        if (rDone && rd.rlast) begin
          state_next = IDLE;
        end
      end
      default: state_next = IDLE;
    endcase
  end

  // state register
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      state_reg <= IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // command ready and address valid follow the state
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      cmdReady_reg <= 1'b0;
      arvalid_reg <= 1'b0;
    end else begin
      cmdReady_reg <= (state_next == IDLE);
      arvalid_reg <= (state_next == ADDR);
    end
  end

  // request fields, frozen from capture until the slave takes them
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      arid_reg <= ARP_ID_RST;
      araddr_reg <= ARP_ADDR_RST;
      arlen_reg <= ARP_LEN_RST;
      arsize_reg <= '0;
      arburst_reg <= '0;
      arlock_reg <= '0;
      arcache_reg <= '0;
      arprot_reg <= '0;
    end else if (cmdTake) begin
      arid_reg <= cmdId;
      araddr_reg <= cmdAddr;
      arlen_reg <= cmdLen;
      arsize_reg <= cmdSize;
      arburst_reg <= cmdBurst;
      arlock_reg <= cmdLock;
      arcache_reg <= cmdCache;
      arprot_reg <= cmdProt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // read ready during the data phase unless user logic stalls
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      rready_reg <= 1'b0;
    end else begin
      rready_reg <= (state_next == DATA) && !datStall;
    end
  end

  // one-cycle beat strobe with captured payload
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      datValid_reg <= 1'b0;
      datId_reg <= ARP_ID_RST;
      datData_reg <= ARP_DATA_RST;
      datResp_reg <= ARP_RESP_OKAY;
      datLast_reg <= 1'b0;
    end else begin
      datValid_reg <= rDone;
      if (rDone) begin
        datId_reg <= rd.rid;
        datData_reg <= rd.rdata;
        datResp_reg <= arp_resp_t'(rd.rresp);
        datLast_reg <= rd.rlast;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs
  assign rd.arid = arid_reg;
  assign rd.araddr = araddr_reg;
  assign rd.arlen = arlen_reg;
  assign rd.arsize = arsize_reg;
  assign rd.arburst = arburst_reg;
  assign rd.arlock = arlock_reg;
  assign rd.arcache = arcache_reg;
  assign rd.arprot = arprot_reg;
  assign rd.arvalid = arvalid_reg;
  assign rd.rready = rready_reg;
  assign cmdReady = cmdReady_reg;
  assign datValid = datValid_reg;
  assign datId = datId_reg;
  assign datData = datData_reg;
  assign datResp = datResp_reg;
  assign datLast = datLast_reg;

endmodule // arp_master

//--- arp_pkg.sv
// shared constants and types for the read channel port
package arp_pkg;

  // field widths
  localparam int ARP_ID_W = 4;
  localparam int ARP_ADDR_W = 32;
  localparam int ARP_LEN_W = 4;
  localparam int ARP_SIZE_W = 3;
  localparam int ARP_BURST_W = 2;
  localparam int ARP_LOCK_W = 2;
  localparam int ARP_CACHE_W = 4;
  localparam int ARP_PROT_W = 3;
  localparam int ARP_DATA_W = 32;
  localparam int ARP_RESP_W = 2;

  // read response kinds
  typedef enum logic [1:0] {
    ARP_RESP_OKAY = 2'h0,
    ARP_RESP_EXOKAY = 2'h1,
    ARP_RESP_SLVERR = 2'h2,
    ARP_RESP_DECERR = 2'h3
  } arp_resp_t;

  // burst kinds
  localparam logic [1:0] ARP_BURST_FIXED = 2'h0;
  localparam logic [1:0] ARP_BURST_INCR = 2'h1;
  localparam logic [1:0] ARP_BURST_WRAP = 2'h2;

  // reset values, and the constant one used in address arithmetic
  localparam logic [31:0] ARP_ADDR_RST = 32'h0000_0000;
  localparam logic [31:0] ARP_DATA_RST = 32'h0000_0000;
  localparam logic [3:0] ARP_ID_RST = 4'h0;
  localparam logic [3:0] ARP_LEN_RST = 4'h0;
  localparam logic [31:0] ARP_ONE = 32'h0000_0001;

endpackage

//--- arp_rd_assertions.sv
// concurrent checks on the read channel wires between the two ends
`timescale 1ns/1ps
module arp_rd_assertions
  import arp_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // address channel
  input wire logic [ARP_ID_W-1:0] arid,
  input wire logic [ARP_ADDR_W-1:0] araddr,
  input wire logic [ARP_LEN_W-1:0] arlen,
  input wire logic arvalid,
  input wire logic arready,
  // data channel
  input wire logic [ARP_ID_W-1:0] rid,
  input wire logic [ARP_DATA_W-1:0] rdata,
  input wire logic [ARP_RESP_W-1:0] rresp,
  input wire logic rlast,
  input wire logic rvalid,
  input wire logic rready
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);

  logic [3:0] id_reg;
  logic [3:0] len_reg;
  logic [3:0] beat_reg;
  logic busy_reg;

  ////////////////////////////////////////////////////////////////////////////
  // burst in flight: its tag, its length and the beats taken so far
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      id_reg <= ARP_ID_RST;
      len_reg <= ARP_LEN_RST;
      beat_reg <= 4'h0;
      busy_reg <= 1'b0;
    end else if (arvalid && arready) begin
      id_reg <= arid;
      len_reg <= arlen;
      beat_reg <= 4'h0;
      busy_reg <= 1'b1;
    end else if (rvalid && rready) begin
      beat_reg <= beat_reg + 4'h1;
      if (rlast) begin
        busy_reg <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // handshake steps
  sequence arTake;
    arvalid && arready;
  endsequence
  sequence lastTake;
    rvalid && rready && rlast;
  endsequence
  sequence rWait;
    rvalid && !rready;
  endsequence

  AST_AR_HOLD: assert property (arvalid && !arready |=>
    arvalid && $stable({arid, araddr, arlen}))
    else $error("address request changed before it was taken");
  AST_AR_BUSY: assert property (busy_reg |-> !arready)
    else $error("address ready high while a burst is in flight");
  AST_AR_REOPEN: assert property (lastTake |-> ##[1:3] arready)
    else $error("address ready not back after the last beat");
  AST_R_HOLD: assert property (rWait |=>
    rvalid && $stable({rid, rdata, rresp, rlast}))
    else $error("read beat changed before it was taken");
  AST_RID: assert property (rvalid |-> rid == id_reg)
    else $error("read tag differs from the request tag");
  AST_LAST: assert property (rvalid |-> rlast == (beat_reg == len_reg))
    else $error("last flag on the wrong beat");
  AST_R_IDLE: assert property (rvalid |-> busy_reg)
    else $error("read valid with no burst in flight");
  AST_R_DROP: assert property (rvalid && rready |=> !rvalid)
    else $error("read valid stayed high after the beat was taken");
  AST_FIRST_BEAT: assert property (arTake |-> ##[2:200] rvalid)
    else $error("no beat returned after the request");
endmodule // arp_rd_assertions

//--- arp_rd_if.sv
// read address and read data channels joining master and slave
`timescale 1ns/1ps
interface arp_rd_if;
  import arp_pkg::*;

  // read address channel
  logic [ARP_ID_W-1:0] arid;
  logic [ARP_ADDR_W-1:0] araddr;
  logic [ARP_LEN_W-1:0] arlen;
  logic [ARP_SIZE_W-1:0] arsize;
  logic [ARP_BURST_W-1:0] arburst;
  logic [ARP_LOCK_W-1:0] arlock;
  logic [ARP_CACHE_W-1:0] arcache;
  logic [ARP_PROT_W-1:0] arprot;
  logic arvalid;
  logic arready;

  // read data channel
  logic [ARP_ID_W-1:0] rid;
  logic [ARP_DATA_W-1:0] rdata;
  logic [ARP_RESP_W-1:0] rresp;
  logic rlast;
  logic rvalid;
  logic rready;

  // master end
  modport master (
    output arid, araddr, arlen, arsize, arburst, arlock, arcache, arprot,
    output arvalid, rready,
    input arready, rid, rdata, rresp, rlast, rvalid
  );

  // slave end
  modport slave (
    input arid, araddr, arlen, arsize, arburst, arlock, arcache, arprot,
    input arvalid, rready,
    output arready, rid, rdata, rresp, rlast, rvalid
  );

endinterface // arp_rd_if

//--- arp_slave.sv
// slave end of the read channel port: takes bursts, returns beats
// Notes on behaviour
// - master tags each read request with 4-bit id
// - only start address sent; later beats derived
// - length field fixes beat count; slave returns exactly
// - size and burst type steer beat address
// - master drives lock, cache and protection fields
// - master holds request stable until address ready
// - address ready high only when slave can accept
// - every returned beat carries the request id
// - read data bus is 32 bits wide
// - each beat carries one of four responses
// - last flag only on final beat of burst
// - read valid high only while data is presented
// - master read ready shows it can take data
`timescale 1ns/1ps
module arp_slave
  import arp_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // link to master
  arp_rd_if.slave rd,
  // fetch request to local storage
  output logic memReq,
  output logic [ARP_ADDR_W-1:0] memAddr,
  output logic [ARP_SIZE_W-1:0] memSize,
  output logic [ARP_LOCK_W-1:0] memLock,
  output logic [ARP_CACHE_W-1:0] memCache,
  output logic [ARP_PROT_W-1:0] memProt,
  // fetch answer from local storage
  input wire logic memAck,
  input wire logic [ARP_DATA_W-1:0] memData,
  input wire arp_resp_t memResp
);

  typedef enum logic [1:0] {IDLE, FETCH, SEND} arp_sstate_t;

  ////////////////////////////////////////////////////////////////////////
  // beat address arithmetic
  function automatic logic [31:0] arpNextAddr(
    input logic [31:0] addr,
    input logic [2:0] size,
    input logic [1:0] burst,
    input logic [3:0] len
  );
    logic [31:0] step;
    logic [31:0] span;
    logic [31:0] mask;
    logic [31:0] inc;
    step = ARP_ONE << size;
    span = step * ({28'h000_0000, len} + ARP_ONE);
    mask = span - ARP_ONE;
    inc = addr + step;
    case (burst)
      ARP_BURST_FIXED: arpNextAddr = addr;
      ARP_BURST_WRAP: arpNextAddr = (addr & ~mask) | (inc & mask);
      default: arpNextAddr = inc;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // registers
  arp_sstate_t state_reg;
  arp_sstate_t state_next;
  logic arready_reg;
  logic [ARP_ID_W-1:0] id_reg;
  logic [ARP_ADDR_W-1:0] addr_reg;
  logic [ARP_LEN_W-1:0] len_reg;
  logic [ARP_LEN_W-1:0] left_reg;
  logic [ARP_SIZE_W-1:0] size_reg;
  logic [ARP_BURST_W-1:0] burst_reg;
  logic [ARP_LOCK_W-1:0] lock_reg;
  logic [ARP_CACHE_W-1:0] cache_reg;
  logic [ARP_PROT_W-1:0] prot_reg;
  logic memReq_reg;
  logic rvalid_reg;
  logic rlast_reg;
  logic [ARP_DATA_W-1:0] rdata_reg;
  arp_resp_t rresp_reg;
  logic arTake;
  logic rDone;

  // handshakes complete only with valid and ready both high
  assign arTake = rd.arvalid && arready_reg;
  assign rDone = rvalid_reg && rd.rready;

  ////////////////////////////////////////////////////////////////////////
  // state sequencing
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      IDLE: begin
        if (arTake) begin
          state_next = FETCH;
        end
      end
      FETCH: begin
        if (memAck) begin
          state_next = SEND;
        end
      end
      SEND: begin
        if (rDone) begin
          // exactly len+1 beats, then back to idle
          state_next = rlast_reg ? IDLE : FETCH;
        end
      end
      default: state_next = IDLE;
    endcase
  end

  // state register
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      state_reg <= IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // address ready only while idle, one burst in flight at a time
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      arready_reg <= 1'b0;
    end else begin
      arready_reg <= (state_next == IDLE);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // request capture; master holds fields until taken
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      id_reg <= ARP_ID_RST;
      len_reg <= ARP_LEN_RST;
      size_reg <= '0;
      burst_reg <= '0;
      lock_reg <= '0;
      cache_reg <= '0;
      prot_reg <= '0;
    end else if (arTake) begin
      id_reg <= rd.arid;
      len_reg <= rd.arlen;
      size_reg <= rd.arsize;
      burst_reg <= rd.arburst;
      lock_reg <= rd.arlock;
      cache_reg <= rd.arcache;
      prot_reg <= rd.arprot;
    end
  end

  // beat address: start address, then derived per beat
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      addr_reg <= ARP_ADDR_RST;
    end else if (arTake) begin
      addr_reg <= rd.araddr;
    end else if (rDone) begin
      addr_reg <= arpNextAddr(addr_reg, size_reg, burst_reg, len_reg);
    end
  end

  // beats still owed after the current one
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      left_reg <= ARP_LEN_RST;
    end else if (arTake) begin
      left_reg <= rd.arlen;
    end else if (rDone && !rlast_reg) begin
      left_reg <= left_reg - 4'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // fetch strobe to local storage, held until acknowledged
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      memReq_reg <= 1'b0;
    end else begin
      memReq_reg <= (state_next == FETCH) && !(state_reg == FETCH && memAck);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // read data beat: loaded on fetch answer, held until taken
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      rvalid_reg <= 1'b0;
    end else if (state_reg == FETCH && memAck) begin
      rvalid_reg <= 1'b1;
    end else if (rDone) begin
      rvalid_reg <= 1'b0;
    end
  end

  // payload of the beat; stable while valid waits for ready
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      rdata_reg <= ARP_DATA_RST;
      rresp_reg <= ARP_RESP_OKAY;
      rlast_reg <= 1'b0;
    end else if (state_reg == FETCH && memAck) begin
      rdata_reg <= memData;
      rresp_reg <= memResp;
      rlast_reg <= (left_reg == ARP_LEN_RST);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs
  assign rd.arready = arready_reg;
  assign rd.rid = id_reg;
  assign rd.rdata = rdata_reg;
  assign rd.rresp = rresp_reg;
  assign rd.rlast = rlast_reg;
  assign rd.rvalid = rvalid_reg;
  assign memReq = memReq_reg;
  assign memAddr = addr_reg;
  assign memSize = size_reg;
  assign memLock = lock_reg;
  assign memCache = cache_reg;
  assign memProt = prot_reg;

endmodule // arp_slave

//--- testbench.sv
// bench joining master and slave ends, with a local storage model
`timescale 1ns/1ps
module testbench;
  import arp_pkg::*;
  logic mclk, sys_rst, cmdValid, cmdReady, datStall, datValid, datLast;
  logic memReq, memAck;
  logic [3:0] cmdId, cmdLen, cmdCache, datId, memCache;
  logic [2:0] cmdSize, cmdProt, memSize, memProt;
  logic [1:0] cmdBurst, cmdLock, memLock;
  logic [31:0] cmdAddr, datData, memAddr, memData;
  logic [11:0] attr;
  logic [53:0] r;
  arp_resp_t memResp, datResp;
  int nErrors, samplesChecked, seed, w;
  logic [38:0] expQ[$];
  logic [53:0] reqQ[$];

  arp_rd_if rd ();
  arp_master i_arp_master (.mclk(mclk), .sys_rst(sys_rst), .rd(rd.master),
    .cmdValid(cmdValid), .cmdReady(cmdReady), .cmdId(cmdId),
    .cmdAddr(cmdAddr), .cmdLen(cmdLen), .cmdSize(cmdSize),
    .cmdBurst(cmdBurst), .cmdLock(cmdLock), .cmdCache(cmdCache),
    .cmdProt(cmdProt), .datStall(datStall), .datValid(datValid),
    .datId(datId), .datData(datData), .datResp(datResp), .datLast(datLast));
  arp_slave i_arp_slave (.mclk(mclk), .sys_rst(sys_rst), .rd(rd.slave),
    .memReq(memReq), .memAddr(memAddr), .memSize(memSize),
    .memLock(memLock), .memCache(memCache), .memProt(memProt),
    .memAck(memAck), .memData(memData), .memResp(memResp));
  arp_rd_assertions i_arp_rd_assertions (.mclk(mclk), .sys_rst(sys_rst),
    .arid(rd.arid), .araddr(rd.araddr), .arlen(rd.arlen),
    .arvalid(rd.arvalid), .arready(rd.arready), .rid(rd.rid),
    .rdata(rd.rdata), .rresp(rd.rresp), .rlast(rd.rlast),
    .rvalid(rd.rvalid), .rready(rd.rready));

  ////////////////////////////////////////////////////////////////////////////
  // clock
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  // storage contents are a fixed scramble of the address
  function automatic logic [31:0] dataOf(input logic [31:0] a);
    return a ^ 32'hC3C3_0F0F;
  endfunction

  // compare one returned beat
  task automatic chkBeat(input logic [38:0] e, input logic [38:0] g);
    samplesChecked++;
    if (g !== e) begin
      nErrors++;
      $display("[FAIL] beat exp %h got %h", e, g);
    end
  endtask

  // compare request fields
  task automatic chkReq(input string nm, input logic [53:0] e,
                        input logic [53:0] g);
    samplesChecked++;
    if (g !== e) begin
      nErrors++;
      $display("[FAIL] %s exp %h got %h", nm, e, g);
    end
  endtask

  // closing report and verdict
  task automatic endOfTest;
    $display("checks %0d errors %0d", samplesChecked, nErrors);
    if (nErrors == 0 && samplesChecked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // offer one command, note its request and every beat it must return
  task automatic issue(input logic [3:0] id, input logic [3:0] len,
    input logic [31:0] a, input logic [2:0] sz, input logic [1:0] bt);
    logic [31:0] cur;
    logic [31:0] tot;
    logic [8:0] at;
    at = 9'($random(seed));
    cmdId <= id;
    cmdAddr <= a;
    cmdLen <= len;
    cmdSize <= sz;
    cmdBurst <= bt;
    {cmdLock, cmdCache, cmdProt} <= at;
    cmdValid <= 1'b1;
    do @(posedge mclk); while (cmdReady !== 1'b1);
    reqQ.push_back({id, a, len, sz, bt, at});
    cur = a;
    tot = ({28'h0, len} + 32'h1) << sz;
    for (int i = 0; i <= int'(len); i++) begin
      expQ.push_back({id, dataOf(cur), cur[3:2], i == int'(len)});
      if (bt == ARP_BURST_WRAP) begin
        cur = (cur & ~(tot - 1)) | ((cur + (32'h1 << sz)) & (tot - 1));
      end else if (bt != ARP_BURST_FIXED) begin
        cur = cur + (32'h1 << sz);
      end
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // storage model answering after a random wait; user side stalls at random
  always @(posedge mclk) begin
    memAck <= memReq && (($random(seed) & 1) != 0);
    memData <= dataOf(memAddr);
    memResp <= arp_resp_t'(memAddr[3:2]);
    datStall <= ($random(seed) & 3) == 0;
  end

  // watch beats, address requests and fetches
  always @(posedge mclk) begin
    if (datValid === 1'b1) begin
      if (expQ.size() == 0) begin
        nErrors++;
        $display("[FAIL] beat exp none got %h", datData);
      end else begin
        chkBeat(expQ.pop_front(), {datId, datData, datResp, datLast});
      end
    end
    if (rd.arvalid === 1'b1 && rd.arready === 1'b1 && reqQ.size() != 0) begin
      r = reqQ.pop_front();
      attr = {r[13:11], r[8:0]};
      chkReq("ar", r, {rd.arid, rd.araddr, rd.arlen, rd.arsize,
        rd.arburst, rd.arlock, rd.arcache, rd.arprot});
    end
    if (memReq === 1'b1 && memAck === 1'b1) begin
      chkReq("fetch", {42'h0, attr},
        {42'h0, memSize, memLock, memCache, memProt});
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // watchdog
  initial begin
    #200000;
    nErrors++;
    $display("[FAIL] watchdog exp done got hang");
    endOfTest();
  end

  // reset, then every burst kind at lengths 0, 1, 3, 7 and 15, back to back
  initial begin
    logic [2:0] sz;
    seed = 29;
    nErrors = 0;
    samplesChecked = 0;
    sys_rst = 1'b1;
    {cmdValid, cmdId, cmdAddr, cmdLen, cmdSize} = '0;
    {cmdBurst, cmdLock, cmdCache, cmdProt} = '0;
    {datStall, memAck, memData} = '0;
    memResp = ARP_RESP_OKAY;
    repeat (3) @(posedge mclk);
    chkReq("reset", 54'h0, {52'h0, cmdReady, rd.rvalid});
    sys_rst <= 1'b0;
    for (int b = 0; b < 4; b++) begin
      for (int k = 0; k < 5; k++) begin
        sz = 3'((($random(seed) & 3) % 3));
        issue(4'($random(seed)), 4'((1 << k) - 1),
          32'($random(seed)) & ~((32'h1 << sz) - 1), sz, 2'(b));
      end
    end
    cmdValid <= 1'b0;
    w = 0;
    while (expQ.size() != 0 && w < 5000) begin
      @(posedge mclk);
      w++;
    end
    // beats still owed when the wait runs out count as a mismatch
    if (expQ.size() != 0) begin
      nErrors++;
      $display("[FAIL] beats left exp 0 got %0d", expQ.size());
    end
    repeat (2) @(posedge mclk);
    endOfTest();
  end
endmodule // testbench
